/* dlam_pkg.sv */
// Contract
// - range bits 0-3 pick each DAC span
// - load mode acts only when pin disabled
// - mode 00: msb write updates that DAC
// - mode 01: B updates A+B, D updates C+D
// - mode 10: only D write updates all four
// - mode 11: only strobe register updates outputs
// - strobe bits 0-3 update DAC A-D alone
// - strobe bits self-clear, always read zero
// - strobe bit 4 picks reference for A/B
// - strobe bit 5 picks reference for C/D
// - set mask bit blocks its alarm source
// - mask1 bits 0-4 gate limit/fault sources
// - mask1 bits 5-7 gate aux inputs 2-4
// - mask2 bit 4 gates both supply limits
// - all four registers reset to zero
// - control bit picks pin or register updates
package dlam_pkg;
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_DAC_RANGE = 12'h01b;
  localparam logic [11:0] IDX_LOAD_STROBE = 12'h01c;
  localparam logic [11:0] IDX_MASK_FIRST = 12'h01d;
  localparam logic [11:0] IDX_MASK_SECOND = 12'h01e;
  localparam logic [11:0] IDX_UPDATE_CTRL = 12'h030;
  localparam logic [11:0] IDX_STATUS_FIRST = 12'h031;
  localparam logic [11:0] IDX_STATUS_SECOND = 12'h032;
  localparam logic [11:0] IDX_DAC_DATA = 12'h040;
  localparam int NUM_DAC = 4;
  localparam int NUM_EVENTS = 10;
  localparam int RANGE_LSB = 0;
  localparam int MODE_LSB = 4;
  localparam int REF_AB_BIT = 4;
  localparam int REF_CD_BIT = 5;
  localparam int SUPPLY_MASK_BIT = 4;
  localparam int REG_CTRL_BIT = 0;
  localparam logic [7:0] RANGE_WR_MASK = 8'h3f;
  localparam logic [7:0] MASK2_WR_MASK = 8'h10;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_PAIR = 2'h1;
  localparam logic [1:0] MODE_ALL_ON_D = 2'h2;
  localparam logic [1:0] MODE_STROBE = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    DLAM_RD_IDLE = 2'b01,
    DLAM_RD_BUSY = 2'b10
  } dlam_rd_state_t;
endpackage : dlam_pkg

/* dlam_regs.sv */
module dlam_regs
  import dlam_pkg::*;
#(
  parameter int ADDR_W = 9,
  parameter int DAC_W = 10
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic dac_load_strobe_n,
  input wire logic [NUM_EVENTS-1:0] limit_event,
  output logic [NUM_DAC-1:0] dac_range,
  output logic [1:0] dac_ref_internal,
  output logic [NUM_DAC*DAC_W-1:0] dac_out_code,
  output logic [NUM_DAC-1:0] dac_update,
  output logic alarm_irq
);

  // refuse widths the decode and code mask cannot serve
  if (ADDR_W < 9 || ADDR_W > 12) begin : g_bad_addr_w
    $error("ADDR_W must be 9 to 12");
  end
  if (DAC_W < 1 || DAC_W > 16) begin : g_bad_dac_w
    $error("DAC_W must be 1 to 16");
  end

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] idx);
    logic [11:0] byte_addr;
    byte_addr = {idx[9:0], 2'b00};
    return a[ADDR_W-1:2] == byte_addr[ADDR_W-1:2];
  endfunction : hit

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic m;
    m = hit(a, IDX_DAC_RANGE) | hit(a, IDX_LOAD_STROBE) | hit(a, IDX_MASK_FIRST);
    m = m | hit(a, IDX_MASK_SECOND) | hit(a, IDX_UPDATE_CTRL) | hit(a, IDX_STATUS_FIRST);
    m = m | hit(a, IDX_STATUS_SECOND);
    for (int i = 0; i < NUM_DAC; i++) begin
      m = m | hit(a, IDX_DAC_DATA + 12'(i));
    end
    return m;
  endfunction : mapped

  logic aw_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic w_held;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  dlam_rd_state_t rd_state;
  logic [7:0] range_reg;
  logic [1:0] ref_reg;
  logic [7:0] mask1;
  logic [7:0] mask2;
  logic reg_ctrl;
  logic [7:0] status1;
  logic status2;
  logic pin_q;
  logic [15:0] dac_in [NUM_DAC];
  logic [15:0] next_in [NUM_DAC];
  logic [NUM_DAC-1:0] next_update;
  logic [31:0] rd_mux;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = rd_state == DLAM_RD_IDLE;

  wire wr_fire = aw_held && w_held && !s_axi_bvalid;
  wire wr_ok = wr_fire && mapped(aw_addr_q);
  wire lane0 = w_strb_q[0];
  wire lane1 = w_strb_q[1];
  wire wr_range = wr_fire && hit(aw_addr_q, IDX_DAC_RANGE) && lane0;
  wire wr_strobe = wr_fire && hit(aw_addr_q, IDX_LOAD_STROBE) && lane0;
  wire wr_mask1 = wr_fire && hit(aw_addr_q, IDX_MASK_FIRST) && lane0;
  wire wr_mask2 = wr_fire && hit(aw_addr_q, IDX_MASK_SECOND) && lane0;
  wire wr_ctrl = wr_fire && hit(aw_addr_q, IDX_UPDATE_CTRL) && lane0;
  wire wr_stat1 = wr_fire && hit(aw_addr_q, IDX_STATUS_FIRST) && lane0;
  wire wr_stat2 = wr_fire && hit(aw_addr_q, IDX_STATUS_SECOND) && lane0;
  wire [1:0] load_mode = range_reg[MODE_LSB+1:MODE_LSB];
  wire pin_fall = pin_q && !dac_load_strobe_n;
  wire [15:0] code_mask = 16'((17'h1 << DAC_W) - 17'h1);

  // data register writes and msb-byte detection
  logic [NUM_DAC-1:0] msb_write;
  always_comb begin
    for (int i = 0; i < NUM_DAC; i++) begin
      msb_write[i] = wr_fire && hit(aw_addr_q, IDX_DAC_DATA + 12'(i)) && lane1;
      next_in[i] = dac_in[i];
      if (wr_fire && hit(aw_addr_q, IDX_DAC_DATA + 12'(i))) begin
        next_in[i][7:0] = lane0 ? w_data_q[7:0] : dac_in[i][7:0];
        next_in[i][15:8] = lane1 ? w_data_q[15:8] : dac_in[i][15:8];
        next_in[i] = next_in[i] & code_mask;
      end
    end
  end

  always_comb begin
    next_update = '0;
    if (!reg_ctrl) begin
      next_update = {NUM_DAC{pin_fall}};
    end else begin
      case (load_mode)
        MODE_SINGLE: next_update = msb_write;
        MODE_PAIR: next_update = {msb_write[3], msb_write[3], msb_write[1], msb_write[1]};
        MODE_ALL_ON_D: next_update = {NUM_DAC{msb_write[3]}};
        MODE_STROBE: next_update = wr_strobe ? w_data_q[3:0] : 4'h0;
        default: next_update = '0;
      endcase
    end
  end

  // write address and data capture, response
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      aw_addr_q <= '0;
      w_held <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read mux; strobe bits read as zero
  always_comb begin
    rd_mux = 32'h0;
    if (hit(s_axi_araddr, IDX_DAC_RANGE)) rd_mux[7:0] = range_reg;
    if (hit(s_axi_araddr, IDX_LOAD_STROBE)) rd_mux[7:0] = {2'b00, ref_reg, 4'h0};
    if (hit(s_axi_araddr, IDX_MASK_FIRST)) rd_mux[7:0] = mask1;
    if (hit(s_axi_araddr, IDX_MASK_SECOND)) rd_mux[7:0] = mask2;
    if (hit(s_axi_araddr, IDX_UPDATE_CTRL)) rd_mux[REG_CTRL_BIT] = reg_ctrl;
    if (hit(s_axi_araddr, IDX_STATUS_FIRST)) rd_mux[7:0] = status1;
    if (hit(s_axi_araddr, IDX_STATUS_SECOND)) rd_mux[SUPPLY_MASK_BIT] = status2;
    for (int i = 0; i < NUM_DAC; i++) begin
      if (hit(s_axi_araddr, IDX_DAC_DATA + 12'(i))) rd_mux[15:0] = dac_in[i];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_state <= DLAM_RD_IDLE;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      case (rd_state)
        DLAM_RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state <= DLAM_RD_BUSY;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
          end
        end
        DLAM_RD_BUSY: begin
          if (s_axi_rready) begin
            rd_state <= DLAM_RD_IDLE;
            s_axi_rvalid <= 1'b0;
          end
        end
        default: rd_state <= DLAM_RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      range_reg <= REG_RESET;
      ref_reg <= 2'b00;
      mask1 <= REG_RESET;
      mask2 <= REG_RESET;
      reg_ctrl <= 1'b0;
    end else begin
      if (wr_range) range_reg <= w_data_q[7:0] & RANGE_WR_MASK;
      if (wr_strobe) ref_reg <= w_data_q[REF_CD_BIT:REF_AB_BIT];
      if (wr_mask1) mask1 <= w_data_q[7:0];
      if (wr_mask2) mask2 <= w_data_q[7:0] & MASK2_WR_MASK;
      if (wr_ctrl) reg_ctrl <= w_data_q[REG_CTRL_BIT];
    end
  end

  // sticky events, set wins over clear
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      status1 <= 8'h00;
      status2 <= 1'b0;
      alarm_irq <= 1'b0;
    end else begin
      status1 <= (status1 & ~(wr_stat1 ? w_data_q[7:0] : 8'h00)) | limit_event[7:0];
      status2 <= (status2 & !(wr_stat2 && w_data_q[SUPPLY_MASK_BIT])) | limit_event[8] | limit_event[9];
      alarm_irq <= |(status1 & ~mask1) | (status2 & !mask2[SUPPLY_MASK_BIT]);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_q <= 1'b1;
      dac_update <= '0;
      dac_out_code <= '0;
      for (int i = 0; i < NUM_DAC; i++) dac_in[i] <= 16'h0;
    end else begin
      pin_q <= dac_load_strobe_n;
      dac_update <= next_update;
      for (int i = 0; i < NUM_DAC; i++) begin
        dac_in[i] <= next_in[i];
        if (next_update[i]) dac_out_code[i*DAC_W +: DAC_W] <= next_in[i][DAC_W-1:0];
      end
    end
  end

  assign dac_range = range_reg[RANGE_LSB+3:RANGE_LSB];
  assign dac_ref_internal = ref_reg;

  sequence s_msb_write(logic [1:0] m, int k);
    reg_ctrl && load_mode == m && msb_write[k];
  endsequence

  property p_single;
    @(posedge core_clk) disable iff (!rst_b) s_msb_write(MODE_SINGLE, 0) |=> dac_update == 4'h1;
  endproperty
  a_single: assert property (p_single) else $error("mode 00 write to A misrouted");

  property p_pair;
    @(posedge core_clk) disable iff (!rst_b) s_msb_write(MODE_PAIR, 1) |=> dac_update == 4'h3;
  endproperty
  a_pair: assert property (p_pair) else $error("mode 01 write to B misrouted");

  property p_all_on_d;
    @(posedge core_clk) disable iff (!rst_b)
      reg_ctrl && load_mode == MODE_ALL_ON_D && !msb_write[3] |=> dac_update == 4'h0;
  endproperty
  a_all_on_d: assert property (p_all_on_d) else $error("mode 10 updated without D write");

  property p_strobe_only;
    @(posedge core_clk) disable iff (!rst_b)
      reg_ctrl && load_mode == MODE_STROBE && !wr_strobe |=> dac_update == 4'h0;
  endproperty
  a_strobe_only: assert property (p_strobe_only) else $error("mode 11 updated without strobe");

  property p_strobe_bits;
    @(posedge core_clk) disable iff (!rst_b)
      reg_ctrl && load_mode == MODE_STROBE && wr_strobe |=> dac_update == $past(w_data_q[3:0]);
  endproperty
  a_strobe_bits: assert property (p_strobe_bits) else $error("strobe bits mismatch update");

  property p_strobe_read_zero;
    @(posedge core_clk) disable iff (!rst_b)
      s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, IDX_LOAD_STROBE) |=> s_axi_rdata[3:0] == 4'h0;
  endproperty
  a_strobe_read_zero: assert property (p_strobe_read_zero) else $error("strobe bits read nonzero");

  property p_masked;
    @(posedge core_clk) disable iff (!rst_b)
      (mask1 == 8'hff && mask2[SUPPLY_MASK_BIT]) [*2] |-> !alarm_irq;
  endproperty
  a_masked: assert property (p_masked) else $error("alarm raised by masked source");

  property p_unmasked_event;
    @(posedge core_clk) disable iff (!rst_b)
      limit_event[0] && !mask1[0] ##1 !mask1[0] |=> alarm_irq;
  endproperty
  a_unmasked_event: assert property (p_unmasked_event) else $error("enabled source gave no alarm");

  property p_pin_update;
    @(posedge core_clk) disable iff (!rst_b) !reg_ctrl && pin_fall |=> dac_update == 4'hf;
  endproperty
  a_pin_update: assert property (p_pin_update) else $error("pin edge did not update all");

  property p_hold_code;
    @(posedge core_clk) disable iff (!rst_b) dac_update == 4'h0 |-> $stable(dac_out_code);
  endproperty
  a_hold_code: assert property (p_hold_code) else $error("output code changed without update");

  property p_single_d;
    @(posedge core_clk) disable iff (!rst_b)
      s_msb_write(MODE_SINGLE, 3) |=> dac_update == 4'h8;
  endproperty
  a_single_d: assert property (p_single_d) else $error("mode 00 write to D misrouted");

  property p_pair_cd;
    @(posedge core_clk) disable iff (!rst_b)
      s_msb_write(MODE_PAIR, 3) |=> dac_update == 4'hc;
  endproperty
  a_pair_cd: assert property (p_pair_cd) else $error("mode 01 write to D misrouted");

  property p_all_four;
    @(posedge core_clk) disable iff (!rst_b)
      s_msb_write(MODE_ALL_ON_D, 3) |=> dac_update == 4'hf;
  endproperty
  a_all_four: assert property (p_all_four) else $error("mode 10 write to D not global");

  property p_pin_ignored;
    @(posedge core_clk) disable iff (!rst_b)
      !reg_ctrl && !pin_fall |=> dac_update == 4'h0;
  endproperty
  a_pin_ignored: assert property (p_pin_ignored) else $error("update under pin control without edge");

  property p_range_follow;
    @(posedge core_clk) disable iff (!rst_b)
      wr_range |=> dac_range == $past(w_data_q[RANGE_LSB+3:RANGE_LSB]);
  endproperty
  a_range_follow: assert property (p_range_follow) else $error("span bits not taken from write");

  property p_ref_follow;
    @(posedge core_clk) disable iff (!rst_b)
      wr_strobe |=> dac_ref_internal == $past(w_data_q[REF_CD_BIT:REF_AB_BIT]);
  endproperty
  a_ref_follow: assert property (p_ref_follow) else $error("reference selects not taken from write");

  property p_limit_alarm;
    @(posedge core_clk) disable iff (!rst_b)
      (status1 & ~mask1) != 8'h00 |=> alarm_irq;
  endproperty
  a_limit_alarm: assert property (p_limit_alarm) else $error("enabled limit source gave no alarm");

  property p_supply_alarm;
    @(posedge core_clk) disable iff (!rst_b)
      status2 && !mask2[SUPPLY_MASK_BIT] |=> alarm_irq;
  endproperty
  a_supply_alarm: assert property (p_supply_alarm) else $error("enabled supply source gave no alarm");

  property p_supply_masked;
    @(posedge core_clk) disable iff (!rst_b)
      mask2[SUPPLY_MASK_BIT] && (status1 & ~mask1) == 8'h00 |=> !alarm_irq;
  endproperty
  a_supply_masked: assert property (p_supply_masked) else $error("masked supply source raised alarm");

  property p_reset_zero;
    @(posedge core_clk)
      !rst_b |=> range_reg == REG_RESET && ref_reg == 2'b00 && mask1 == REG_RESET && mask2 == REG_RESET;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("register not zero after reset");

endmodule : dlam_regs

/* dlam_host.sv */
module dlam_host (
  input wire logic core_clk,
  output logic [8:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [8:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
  task automatic wr(input logic [8:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int n;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (n == 50) tb.stall();
  endtask : wr
  task automatic rd(input logic [8:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 50) tb.stall();
  endtask : rd
endmodule : dlam_host

/* tb.sv */
module tb
  import dlam_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic pin_n = 1'b1;
  logic [9:0] ev = '0;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, irq;
  logic [8:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed = 32'h1cc5;
  logic [3:0] wstrb, rng, upd, seen, span;
  logic [1:0] bresp, rresp, refi, r, refo;
  logic [39:0] code;
  int bufv[4], outv[4], err_total, samples_checked, md, k;
  dlam_regs #(.ADDR_W(9), .DAC_W(10)) dlam_regs_i (.core_clk(core_clk), .rst_b(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .dac_load_strobe_n(pin_n), .limit_event(ev), .dac_range(span),
    .dac_ref_internal(refo), .dac_out_code(code), .dac_update(upd), .alarm_irq(irq));
  dlam_host dlam_host_i (.core_clk(core_clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) seen <= seen | upd;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [8:0] ad(input logic [11:0] i);
    return 9'(i << 2);
  endfunction : ad
  function automatic logic [39:0] pk();
    logic [39:0] p;
    for (int j = 0; j < 4; j++) p[j*10 +: 10] = outv[j][9:0];
    return p;
  endfunction : pk
  function automatic logic [3:0] emask(input int m, input int i);
    case (m)
      0: return 4'h1 << i;
      1: return i == 1 ? 4'h3 : i == 3 ? 4'hc : 4'h0;
      2: return i == 3 ? 4'hf : 4'h0;
      default: return 4'h0;
    endcase
  endfunction : emask
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wreg(input logic [11:0] i, input logic [31:0] d);
    dlam_host_i.wr(ad(i), d, 4'h1, r);
    chk(r, RESP_OKAY);
  endtask : wreg
  task automatic rchk(input logic [8:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    dlam_host_i.rd(a, d, r);
    chk(d, e);
    chk(r, er);
  endtask : rchk
  task automatic settle(input logic [3:0] m);
    @(negedge core_clk);
    chk(seen, m);
    for (int j = 0; j < 4; j++) if (m[j]) outv[j] = bufv[j];
    chk(code, pk());
  endtask : settle
  task automatic dwr(input int i, input logic [3:0] m);
    seed = lfsr(seed);
    bufv[i] = seed[9:0];
    @(negedge core_clk);
    seen = '0;
    dlam_host_i.wr(ad(IDX_DAC_DATA + 12'(i)), {22'h0, seed[9:0]}, 4'h3, r);
    settle(m);
    rchk(ad(IDX_DAC_DATA + 12'(i)), bufv[i], RESP_OKAY);
  endtask : dwr
  task automatic stall;
    err_total++;
    conclude();
  endtask : stall
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  initial begin
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    for (k = 0; k < 4; k++) rchk(ad(IDX_DAC_RANGE + 12'(k)), 0, RESP_OKAY);
    chk(code, 0);
    $display("reset test done");
    seed = lfsr(seed);
    rng = seed[3:0];
    wreg(IDX_UPDATE_CTRL, 1);
    for (md = 0; md < 4; md++) begin
      wreg(IDX_DAC_RANGE, {md[1:0], rng});
      rchk(ad(IDX_DAC_RANGE), {md[1:0], rng}, RESP_OKAY);
      chk(span, rng);
      for (k = 0; k < 4; k++) dwr(k, emask(md, k));
    end
    $display("load mode test done");
    for (k = 0; k < 4; k++) begin
      refi = 2'(3 - k);
      @(negedge core_clk);
      seen = '0;
      wreg(IDX_LOAD_STROBE, {refi, 4'h1 << k});
      settle(4'h1 << k);
      chk(refo, refi);
      rchk(ad(IDX_LOAD_STROBE), {refi, 4'h0}, RESP_OKAY);
    end
    $display("strobe test done");
    wreg(IDX_DAC_RANGE, 0);
    for (k = 0; k < 2; k++) begin
      wreg(IDX_UPDATE_CTRL, k);
      rchk(ad(IDX_UPDATE_CTRL), k, RESP_OKAY);
      dwr(0, 4'(k));
      for (int j = 0; j < 4; j++) dwr(j, k ? 4'h1 << j : 4'h0);
      @(negedge core_clk);
      seen = '0;
      @(posedge core_clk);
      pin_n <= 1'b0;
      @(posedge core_clk);
      pin_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      settle(k ? 4'h0 : 4'hf);
    end
    $display("pin test done");
    for (k = 0; k < 10; k++) begin
      seed = lfsr(seed);
      wreg(IDX_MASK_FIRST, seed[7:0]);
      wreg(IDX_MASK_SECOND, {seed[8], 4'h0});
      rchk(ad(IDX_MASK_SECOND), {seed[8], 4'h0}, RESP_OKAY);
      @(posedge core_clk);
      ev <= 10'h1 << k;
      @(posedge core_clk);
      ev <= '0;
      repeat (3) @(posedge core_clk);
      chk(irq, k < 8 ? !seed[k] : !seed[8]);
      wreg(IDX_STATUS_FIRST, 8'hff);
      wreg(IDX_STATUS_SECOND, 8'h10);
      repeat (2) @(posedge core_clk);
      chk(irq, 0);
    end
    wreg(IDX_MASK_FIRST, 8'hff);
    wreg(IDX_MASK_SECOND, 8'h10);
    @(posedge core_clk);
    ev <= 10'h3ff;
    @(posedge core_clk);
    ev <= '0;
    repeat (3) @(posedge core_clk);
    chk(irq, 0);
    rchk(ad(IDX_STATUS_FIRST), 8'hff, RESP_OKAY);
    rchk(ad(IDX_STATUS_SECOND), 8'h10, RESP_OKAY);
    wreg(IDX_MASK_SECOND, 0);
    repeat (3) @(posedge core_clk);
    chk(irq, 1);
    wreg(IDX_STATUS_SECOND, 8'h10);
    wreg(IDX_STATUS_FIRST, 8'hff);
    repeat (2) @(posedge core_clk);
    chk(irq, 0);
    rchk(ad(IDX_STATUS_FIRST), 0, RESP_OKAY);
    $display("alarm test done");
    dlam_host_i.wr(9'h1f0, 32'h5a, 4'h1, r);
    chk(r, RESP_SLVERR);
    rchk(9'h1f0, 0, RESP_SLVERR);
    $display("unmapped test done");
    conclude();
  end
endmodule : tb
